// file: core/acd_defs.svh
// Constants for the sample-clock divider, alignment and power-state block
`ifndef ACD_DEFS_SVH
`define ACD_DEFS_SVH
`define ACD_ALIGN_CTRL_OFS   8'h00
`define ACD_REG_ALIGN_CTRL   12'h100
`define ACD_REG_CLOCK_CTRL   12'h10B
`define ACD_REG_STAB_CTRL    12'h009
`define ACD_REG_POWER_CTRL   12'h008
`define ACD_REG_STATUS       12'h10C
`define ACD_ALIGN_EN_BIT     1
`define ACD_ALIGN_ONCE_BIT   2
`define ACD_ALIGN_CTRL_RST   8'h00
`define ACD_CLOCK_CTRL_RST   8'h00
`define ACD_STAB_CTRL_RST    8'h01
`define ACD_POWER_CTRL_RST   8'h00
`define ACD_RATIO_MAX        3'h7
`define ACD_RELOCK_NS        5000
`define ACD_CLK_NS           10
`define ACD_RELOCK_CYC       ((`ACD_RELOCK_NS) / (`ACD_CLK_NS))
`define ACD_RELOCK_W         9
`endif

// file: core/acd_pkg.sv
// Types for the sample-clock divider, alignment and power-state block
package acd_pkg;
  typedef enum logic [1:0] {ACD_PWR_RUN, ACD_PWR_STANDBY, ACD_PWR_DOWN} acd_pwr_t;
  typedef enum logic [1:0] {ACD_STAB_OFF, ACD_STAB_BYPASS, ACD_STAB_LOCKED} acd_stab_t;
endpackage

// file: core/acd_sync.sv
// Two-flop synchroniser for the alignment input
`timescale 1ns/1ps
`default_nettype none
module acd_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // acd_sync
`default_nettype wire

// file: core/acd_divider.sv
// Integer divider with clear and a 50 % duty output at even ratios when stabilised
`timescale 1ns/1ps
`default_nettype none
module acd_divider (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic       realign,
  input  wire logic [2:0] ratio_m1,
  input  wire logic       even_duty,
  output logic            div_clk,
  output logic [2:0]      phase
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic       wrap;
  logic       hi_raw;
  logic       hi_even;
  assign wrap    = (cnt_r >= ratio_m1);
  assign cnt_nxt = (realign || wrap) ? 3'h0 : 3'(cnt_r + 3'h1);
  // Raw: high for one input period, as the undivided duty would give
  assign hi_raw  = (cnt_nxt == 3'h0);
  // Stabilised: falling edge retimed to half of the divided period, rounded up at odd ratios
  assign hi_even = ({1'b0, cnt_nxt, 1'b0} < (5'(ratio_m1) + 5'h01)) || (ratio_m1 == 3'h0);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= 3'h0;
      div_clk <= 1'b0;
    end else if (!run) begin
      cnt_r   <= 3'h0;
      div_clk <= 1'b0;
    end else begin
      cnt_r   <= cnt_nxt;
      div_clk <= even_duty ? hi_even : hi_raw;
    end
  end
  assign phase = cnt_r;
endmodule // acd_divider
`default_nettype wire

// file: core/acd_clock_power.sv
// Sample-clock divider, alignment, duty stabiliser and power-state control
// Functional notes
// (R1) The sample clock is divided by a programmable ratio from 1 to 8.
// (R2) Ratios 1, 2 and 4 work with the stabiliser on or off.
// (R3) Software must enable the stabiliser for ratios 3, 5, 6, 7 and 8.
// (R4) Bits 1 and 2 of the alignment register pick every-pulse or first-pulse alignment.
// (R5) An accepted alignment pulse returns the divider to its initial count.
// (R6) The alignment input passes a synchroniser on the sample clock before use.
// (R7) The alignment input should arrive already synchronous to the sample clock.
// (R8) The enabled stabiliser gives the divided clock a nominal 50 % duty cycle; the code meets it at even ratios only and rounds up at odd ones.
// (R9) The stabiliser loop need not work below about 20 MHz.
// (R10) After a clock change the stabiliser is bypassed for its relock time.
// (R11) Software should keep the stabiliser on unless the clock rate changes.
// (R12) Power-down follows the pin high or the serial control bit; pin low resumes.
// (R13) In power-down all data output drivers are high impedance.
// (R14) Power-down shuts reference, buffer, bias and internal clock.
// (R15) Standby, set only by serial control, keeps the reference powered.
// (R16) In first-pulse mode further pulses are ignored until the register is written again.
`timescale 1ns/1ps
`default_nettype none
`include "acd_defs.svh"
module acd_clock_power (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        align_in,
  input  wire logic        power_down_pin,
  input  wire logic        clk_rate_change,
  input  wire logic        clk_rate_slow,
  output logic             conv_clk,
  output logic             data_out_oe_n,
  output logic             ref_on,
  output logic             ref_buf_on,
  output logic             bias_on,
  output logic             int_clk_on,
  output logic             stab_locked,
  output logic             align_seen
);
  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] align_ctrl_r;
  logic [7:0] clock_ctrl_r;
  logic [7:0] stab_ctrl_r;
  logic [7:0] power_ctrl_r;
  logic       armed_r;
  logic       armed_nxt;
  logic [`ACD_RELOCK_W-1:0] relock_r;
  logic [`ACD_RELOCK_W-1:0] relock_nxt;
  acd_pkg::acd_pwr_t pwr_r;
  acd_pkg::acd_pwr_t pwr_nxt;
  // One compare per register for the write decodes; read back decodes the same addresses in its own case
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] r);
    return a == r;
  endfunction
  wire wr_align = reg_wr && addr_hit(reg_addr, `ACD_REG_ALIGN_CTRL);
  wire wr_clock = reg_wr && addr_hit(reg_addr, `ACD_REG_CLOCK_CTRL);
  wire wr_stab  = reg_wr && addr_hit(reg_addr, `ACD_REG_STAB_CTRL);
  wire wr_power = reg_wr && addr_hit(reg_addr, `ACD_REG_POWER_CTRL);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      align_ctrl_r <= `ACD_ALIGN_CTRL_RST;
      clock_ctrl_r <= `ACD_CLOCK_CTRL_RST;
      stab_ctrl_r  <= `ACD_STAB_CTRL_RST;
      power_ctrl_r <= `ACD_POWER_CTRL_RST;
    end else begin
      if (wr_align) begin
        align_ctrl_r <= reg_wdata;
      end
      if (wr_clock) begin
        clock_ctrl_r <= {5'h00, reg_wdata[2:0]};
      end
      if (wr_stab) begin
        stab_ctrl_r  <= {7'h00, reg_wdata[0]};
      end
      if (wr_power) begin
        power_ctrl_r <= {6'h00, reg_wdata[1:0]};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Power state
  // Power-down wins over standby so the pin can always force the deepest state
  always_comb begin
    pwr_nxt = acd_pkg::ACD_PWR_RUN;
    if (power_down_pin || power_ctrl_r[0]) begin
      pwr_nxt = acd_pkg::ACD_PWR_DOWN; // R12
    end else if (power_ctrl_r[1]) begin
      pwr_nxt = acd_pkg::ACD_PWR_STANDBY; // R15
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pwr_r <= acd_pkg::ACD_PWR_RUN;
    else        pwr_r <= pwr_nxt;
  end
  wire running = (pwr_r == acd_pkg::ACD_PWR_RUN);
  assign data_out_oe_n = !running; // R13
  assign ref_on        = (pwr_r != acd_pkg::ACD_PWR_DOWN); // R14 R15
  assign ref_buf_on    = running; // R14
  assign bias_on       = running; // R14
  assign int_clk_on    = running; // R14
  ////////////////////////////////////////////////////////////////////////////
  // Alignment
  logic align_s;
  acd_sync u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (align_in),
    .q     (align_s)
  ); // R6 R7
  logic align_s_d_r;
  wire  align_edge = align_s && !align_s_d_r;
  wire  align_en   = align_ctrl_r[`ACD_ALIGN_EN_BIT];
  wire  align_once = align_ctrl_r[`ACD_ALIGN_ONCE_BIT];
  wire  align_take = align_edge && align_en && (!align_once || armed_r); // R4 R16
  // A register write re-arms for the next cycle; a pulse in the same cycle counts only if already armed, and then disarms
  assign armed_nxt = align_take ? 1'b0 : (wr_align ? 1'b1 : armed_r); // R16
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      align_s_d_r <= 1'b0;
      armed_r     <= 1'b1;
      align_seen  <= 1'b0;
    end else begin
      align_s_d_r <= align_s;
      armed_r     <= armed_nxt;
      align_seen  <= align_take ? 1'b1 : (wr_align ? 1'b0 : align_seen);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Duty stabiliser relock
  wire stab_en   = stab_ctrl_r[0];
  wire relocking = (relock_r != '0);
  // Slow clocks never lock; the divider then keeps the raw duty
  assign relock_nxt = clk_rate_change ? `ACD_RELOCK_W'(`ACD_RELOCK_CYC)
                    : (relocking ? `ACD_RELOCK_W'(relock_r - 1'b1) : relock_r); // R10
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) relock_r <= `ACD_RELOCK_W'(`ACD_RELOCK_CYC);
    else        relock_r <= relock_nxt;
  end
  assign stab_locked = stab_en && !relocking && !clk_rate_slow && running; // R8 R9 R10
  ////////////////////////////////////////////////////////////////////////////
  // Divider
  logic [2:0] phase;
  acd_divider u_div (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (running), // R14
    .realign   (align_take), // R5
    .ratio_m1  (clock_ctrl_r[2:0]), // R1 R2 R3 R11
    .even_duty (stab_locked), // R8
    .div_clk   (conv_clk),
    .phase     (phase)
  );
  ////////////////////////////////////////////////////////////////////////////
  // Read back
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `ACD_REG_ALIGN_CTRL: reg_rdata = align_ctrl_r;
        `ACD_REG_CLOCK_CTRL: reg_rdata = clock_ctrl_r;
        `ACD_REG_STAB_CTRL:  reg_rdata = stab_ctrl_r;
        `ACD_REG_POWER_CTRL: reg_rdata = power_ctrl_r;
        `ACD_REG_STATUS:     reg_rdata = {2'h0, phase, align_seen, stab_locked, running};
        default:             reg_rdata = 8'h00;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks
  pd_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    (power_down_pin || power_ctrl_r[0]) |=> data_out_oe_n && !ref_on) // R12 R13 R14
    else $error("power-down did not release outputs");
  standby_ref_a: assert property (@(posedge clk) disable iff (!rst_n)
    (!power_down_pin && power_ctrl_r == 8'h02) |=> ref_on && !bias_on) // R15
    else $error("standby lost reference");
  sequence s_take;
    align_take && running;
  endsequence
  realign_cnt_a: assert property (@(posedge clk) disable iff (!rst_n)
    s_take |=> phase == 3'h0) // R5
    else $error("divider not realigned");
  once_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    (align_once && !armed_r && !wr_align) |-> !align_take) // R16
    else $error("pulse accepted after first");
  ratio_wrap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (running && phase == clock_ctrl_r[2:0] && !align_take && !$past(wr_clock))
      |=> phase == 3'h0) // R1
    else $error("divider wrap wrong");
  relock_byp_a: assert property (@(posedge clk) disable iff (!rst_n)
    clk_rate_change |=> !stab_locked [*8]) // R10
    else $error("stabiliser locked too soon");
  stab_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !stab_en |-> !stab_locked) // R2
    else $error("stabiliser locked while off");
  sync_lat_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(align_s) |-> $past(align_in, 2)) // R6
    else $error("synchroniser latency wrong");
  ////////////////////////////////////////////////////////////////////////////
  // Power checks
  sequence s_pd_req;
    power_down_pin || power_ctrl_r[0];
  endsequence

  pd_clk_off_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    s_pd_req |=> !int_clk_on && !bias_on && !ref_buf_on)
    else $error("power-down left a supply on");

  pd_div_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // R14
    !running |=> !conv_clk && phase == 3'h0)
    else $error("divider ran while stopped");

  pin_resume_a: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (!power_down_pin && power_ctrl_r[1:0] == 2'h0) |=> running && !data_out_oe_n)
    else $error("no resume after pin low");

  standby_oe_a: assert property (@(posedge clk) disable iff (!rst_n) // R15
    (!power_down_pin && power_ctrl_r[1:0] == 2'h2) |=> data_out_oe_n && !ref_buf_on)
    else $error("standby drivers wrong");

  run_on_a: assert property (@(posedge clk) disable iff (!rst_n) // R13 R14
    running |-> !data_out_oe_n && ref_on && ref_buf_on && bias_on && int_clk_on)
    else $error("running with a supply off");

  ////////////////////////////////////////////////////////////////////////////
  // Divider and alignment checks
  ratio_range_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    (running && !$past(wr_clock)) |-> phase <= clock_ctrl_r[2:0])
    else $error("divider count past ratio");

  wr_clock_a: assert property (@(posedge clk) disable iff (!rst_n) // R1
    wr_clock |=> clock_ctrl_r == {5'h00, $past(reg_wdata[2:0])})
    else $error("ratio write lost");

  realign_hi_a: assert property (@(posedge clk) disable iff (!rst_n) // R5 R8
    s_take |=> conv_clk)
    else $error("no clock edge after realign");

  sync_only_a: assert property (@(posedge clk) disable iff (!rst_n) // R6
    align_take |-> $past(align_in, 2) && !$past(align_in, 3))
    else $error("pulse taken without sync delay");

  once_arm_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
    (align_take && align_once) |=> !armed_r)
    else $error("still armed after first pulse");

  once_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
    (align_once && !armed_r && !wr_align) |=> !armed_r)
    else $error("re-armed without write");

  write_arm_a: assert property (@(posedge clk) disable iff (!rst_n) // R16
    (wr_align && !align_take) |=> armed_r)
    else $error("write did not re-arm");

  every_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (align_edge && align_en && !align_once) |=> align_seen)
    else $error("pulse not taken");

  seen_set_a: assert property (@(posedge clk) disable iff (!rst_n) // R5
    align_take |=> align_seen)
    else $error("taken pulse not flagged");

  seen_clr_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (wr_align && !align_take) |=> !align_seen)
    else $error("flag kept over write");

  ////////////////////////////////////////////////////////////////////////////
  // Stabiliser and bus checks
  relock_load_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    clk_rate_change |=> relock_r == `ACD_RELOCK_W'(`ACD_RELOCK_CYC))
    else $error("relock time not loaded");

  relock_step_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (relocking && !clk_rate_change) |=> relock_r == `ACD_RELOCK_W'($past(relock_r) - 1'b1))
    else $error("relock count skipped");

  relock_end_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (relock_r == `ACD_RELOCK_W'(1) && !clk_rate_change) |=> !relocking)
    else $error("relock did not end");

  relock_max_a: assert property (@(posedge clk) disable iff (!rst_n) // R10
    relock_r <= `ACD_RELOCK_W'(`ACD_RELOCK_CYC))
    else $error("relock count out of range");

  slow_nolock_a: assert property (@(posedge clk) disable iff (!rst_n) // R9
    clk_rate_slow |-> !stab_locked)
    else $error("locked on slow clock");

  stop_nolock_a: assert property (@(posedge clk) disable iff (!rst_n) // R8
    !running |-> !stab_locked)
    else $error("locked while stopped");

  wr_stab_a: assert property (@(posedge clk) disable iff (!rst_n) // R2
    wr_stab |=> stab_ctrl_r == {7'h00, $past(reg_wdata[0])})
    else $error("stabiliser write lost");

  rdata_idle_a: assert property (@(posedge clk) disable iff (!rst_n) // R4
    !reg_rd |-> reg_rdata == 8'h00)
    else $error("read data without strobe");
endmodule // acd_clock_power
`default_nettype wire

// file: tb/acd_src.sv
// Far-side model: sample-clock source and system alignment/power logic
`timescale 1ns/1ps
`default_nettype none
module acd_src (
  input  wire logic clk,
  output logic      align_in,
  output logic      power_down_pin,
  output logic      clk_rate_change,
  output logic      clk_rate_slow
);
  initial begin
    align_in = 1'b0;
    power_down_pin = 1'b0;
    clk_rate_change = 1'b0;
    clk_rate_slow = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Launched just after an edge so the pulse is already clock-synchronous
  task automatic align_pulse();
    align_in <= 1'b1;
    repeat (2) @(posedge clk);
    align_in <= 1'b0;
  endtask
  task automatic rate_change();
    clk_rate_change <= 1'b1;
    @(posedge clk);
    clk_rate_change <= 1'b0;
  endtask
  // Levels only; the pin is held until the next call
  task automatic set_lv(input logic pd, input logic slow);
    power_down_pin <= pd;
    clk_rate_slow <= slow;
  endtask
endmodule // acd_src
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the divider, alignment and power-state block
`timescale 1ns/1ps
`default_nettype none
`include "acd_defs.svh"
module testbench;
  logic        clk, rst_n, reg_wr, reg_rd, prev;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, d;
  logic        conv_clk, data_out_oe_n, ref_on, ref_buf_on, bias_on, int_clk_on;
  logic        stab_locked, align_seen, align_in, power_down_pin, rate_chg, rate_slow;
  int          failures, checks_done, cyc, hi_n, rise_n, last_rise, c0, c1, r1;
  int          seed = 96280;
  int          mdl[int];
  logic [11:0] ra[5] = '{12'h100, 12'h10B, 12'h009, 12'h008, 12'h0FF};
  logic [7:0]  mk[5] = '{8'hFF, 8'h07, 8'h01, 8'h03, 8'hFF};
  acd_clock_power u_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .align_in(align_in), .power_down_pin(power_down_pin), .clk_rate_change(rate_chg),
    .clk_rate_slow(rate_slow), .conv_clk(conv_clk), .data_out_oe_n(data_out_oe_n),
    .ref_on(ref_on), .ref_buf_on(ref_buf_on), .bias_on(bias_on), .int_clk_on(int_clk_on),
    .stab_locked(stab_locked), .align_seen(align_seen));
  acd_src u_src (.clk(clk), .align_in(align_in), .power_down_pin(power_down_pin),
    .clk_rate_change(rate_chg), .clk_rate_slow(rate_slow));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sampled on the falling edge so the registered clock output has settled
  always @(negedge clk) begin
    cyc++;
    if (conv_clk === 1'b1) hi_n++;
    if (conv_clk === 1'b1 && prev === 1'b0) begin
      rise_n++;
      last_rise = cyc;
    end
    prev = conv_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // Extra edge after release so a following write never re-raises in the same step
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (mdl.exists(a)) mdl[a] = v;
    @(posedge clk);
  endtask
  task automatic rdm(input logic [11:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    chk("rdata", mdl.exists(a) ? 8'(mdl[a]) : 8'h00, reg_rdata);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(output int c);
    c = cyc;
    u_src.align_pulse();
    repeat (43) @(posedge clk);
  endtask
  function automatic logic [7:0] rel(input int c);
    return 8'((last_rise - c) % 8);
  endfunction
  function automatic logic [7:0] pw();
    return {3'h0, data_out_oe_n, ref_on, ref_buf_on, bias_on, int_clk_on};
  endfunction
  task automatic duty(input int stab);
    for (int n = 1; n <= 8; n++) begin
      if (stab == 0 && !(n inside {1, 2, 4})) continue;
      wr(`ACD_REG_CLOCK_CTRL, 8'(n - 1));
      repeat (3 * n) @(posedge clk);
      hi_n = 0;
      rise_n = 0;
      repeat (4 * n) @(posedge clk);
      chk("high", 8'(stab != 0 ? 4 * ((n + 1) / 2) : 4), 8'(hi_n));
      if (n > 1) chk("rises", 8'h04, 8'(rise_n));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200us;
    failures++;
    wrap_up();
  end
  initial begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    mdl[12'h100] = 0;
    mdl[12'h10B] = 0;
    mdl[12'h009] = 1;
    mdl[12'h008] = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rdm(ra[i]);
    wr(`ACD_REG_CLOCK_CTRL, 8'h03);
    repeat (390) @(posedge clk);
    chk("locked", 8'h00, {7'h00, stab_locked});
    repeat (120) @(posedge clk);
    chk("locked", 8'h01, {7'h00, stab_locked});
    u_src.rate_change();
    repeat (12) @(posedge clk);
    hi_n = 0;
    repeat (16) @(posedge clk);
    chk("raw high", 8'h04, 8'(hi_n));
    chk("locked", 8'h00, {7'h00, stab_locked});
    repeat (520) @(posedge clk);
    chk("locked", 8'h01, {7'h00, stab_locked});
    u_src.set_lv(1'b0, 1'b1);
    u_src.rate_change();
    repeat (600) @(posedge clk);
    chk("locked", 8'h00, {7'h00, stab_locked});
    u_src.set_lv(1'b0, 1'b0);
    u_src.rate_change();
    repeat (520) @(posedge clk);
    duty(1);
    wr(`ACD_REG_ALIGN_CTRL, 8'h02);
    pulse(c0);
    r1 = 32'(rel(c0));
    chk("seen", 8'h01, {7'h00, align_seen});
    pulse(c1);
    chk("align", 8'(r1), rel(c1));
    wr(`ACD_REG_ALIGN_CTRL, 8'h06);
    pulse(c0);
    chk("align", 8'(r1), rel(c0));
    pulse(c1);
    chk("align", 8'(r1), rel(c0));
    wr(`ACD_REG_ALIGN_CTRL, 8'h00);
    pulse(c1);
    chk("align", 8'(r1), rel(c0));
    chk("seen", 8'h00, {7'h00, align_seen});
    wr(`ACD_REG_STAB_CTRL, 8'h00);
    chk("locked", 8'h00, {7'h00, stab_locked});
    duty(0);
    foreach (ra[i]) begin
      d = 8'($random(seed)) & mk[i];
      wr(ra[i], d);
      rdm(ra[i]);
    end
    wr(`ACD_REG_POWER_CTRL, 8'h00);
    u_src.set_lv(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk("power", 8'h10, pw());
    rise_n = 0;
    repeat (16) @(posedge clk);
    chk("rises", 8'h00, 8'(rise_n));
    rdm(`ACD_REG_STATUS);
    u_src.set_lv(1'b0, 1'b0);
    repeat (3) @(posedge clk);
    chk("power", 8'h0F, pw());
    wr(`ACD_REG_POWER_CTRL, 8'h01);
    repeat (2) @(posedge clk);
    chk("power", 8'h10, pw());
    wr(`ACD_REG_POWER_CTRL, 8'h02);
    repeat (2) @(posedge clk);
    chk("standby", 8'h03, {6'h00, data_out_oe_n, ref_on});
    wr(`ACD_REG_POWER_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    chk("power", 8'h0F, pw());
    wrap_up();
  end
endmodule // testbench
`default_nettype wire
